// *** tb/host_pin_model.sv ***
// Host-side pins: the two select pins and the hard reset pin.
// Assumes the bench asks for pin levels and reset pulses on core_clk.
`timescale 1ns/1ns
module host_pin_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [1:0] sel_want,
    input wire logic reset_pulse,
    input wire logic hard_reset_pending,
    output logic input_choice_pin_high,
    output logic input_choice_pin_low,
    output logic hard_reset_pin_b,
    output logic host_may_write
);
    logic [2:0] low_cnt_r; // Cycles the reset pin stays low.

    ////////////////////////////////////////////////////////////////////
    // The reset pin is held low four cycles so the synchroniser sees it.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt_r <= 3'h0;
        end else if (reset_pulse) begin
            low_cnt_r <= 3'h4;
        end else if (low_cnt_r != 3'h0) begin
            low_cnt_r <= low_cnt_r - 3'h1;
        end
    end
    assign hard_reset_pin_b = (low_cnt_r == 3'h0);

    // Select pins follow the bench's wish one edge later.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            {input_choice_pin_high, input_choice_pin_low} <= 2'h0;
        end else begin
            {input_choice_pin_high, input_choice_pin_low} <= sel_want;
        end
    end

    // Writes are withheld while a postponed reset is still counting.
    assign host_may_write = !hard_reset_pending;
endmodule // host_pin_model

// *** tb/test_zero_delay_input_select.sv ***
// Self-checking bench for the zero-delay input selection block.
// Assumes the pin model above and a 25 MHz core clock.
`timescale 1ns/1ns
module test_zero_delay_input_select;
    localparam int HD = 20; // Short postponement so the run stays brief.
    logic core_clk, rst_b, clk_en, reg_wr, reg_rd, reset_pulse, may_wr;
    logic pin_hi, pin_lo, pin_rst_b, hitless, use_fb, loop_closed;
    logic pend, exec;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, act_delay;
    logic [1:0] auto_choice, sel_want, sel, prev;
    logic [11:0] dis, oen;
    integer seed = 32'h7cbb8194;
    int err_count = 0;
    int tests_run = 0;
    int n;
    logic a, en, src;
    logic a_o, en_o; // Settings of the previous random step.
    logic [1:0] nrm, zd, zd_o, hold;

    zero_delay_input_select #(.HARD_DELAY_CYCLES(HD)) i_zero_delay_input_select (
        .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .input_choice_pin_high(pin_hi), .input_choice_pin_low(pin_lo),
        .hard_reset_pin_b(pin_rst_b), .auto_choice(auto_choice),
        .output_disable(dis), .output_enable(oen), .selected_input(sel),
        .hitless_enable(hitless), .use_feedback_input(use_fb),
        .internal_loop_closed(loop_closed), .active_delay(act_delay),
        .hard_reset_pending(pend), .hard_reset_exec(exec));

    host_pin_model i_host_pin_model (
        .core_clk(core_clk), .rst_b(rst_b), .sel_want(sel_want),
        .reset_pulse(reset_pulse), .hard_reset_pending(pend),
        .input_choice_pin_high(pin_hi), .input_choice_pin_low(pin_lo),
        .hard_reset_pin_b(pin_rst_b), .host_may_write(may_wr));

    ////////////////////////////////////////////////////////////////////
    // Clock, and a watchdog sized well beyond the expected run.
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        final_report();
    end

    // Case equality so an unknown never counts as a match.
    task automatic chk_val(input logic [11:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h", $time, what, got);
        end
    endtask
    task automatic chk_cnt(input int got, exp);
        tests_run++;
        if (got != exp) begin
            err_count++;
            $display("unexpected at %0t: delay count %0d", $time, got);
        end
    endtask

    // One write strobe; waits until the host may write.
    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        while (!may_wr) @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data is sampled a full cycle after the strobe is taken.
    task automatic rd(input logic [15:0] ad, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        #1 chk_val({4'h0, reg_rdata}, {4'h0, exp}, "read data");
    endtask
    // Counts cycles from the taken request to the execute pulse; with
    // nothing to postpone, the pulse stands right after the taking edge.
    task automatic count_exec(input bit repeat_pin);
        n = 1;
        #1;
        while (exec !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            reset_pulse <= repeat_pin && (n == 4);
            #1 n++;
        end
    endtask

    // Expected chosen input from the governing table.
    function automatic logic [1:0] exp_sel(input logic a_, en_, src_,
            input logic [1:0] pins, nr, z, pv);
        if (a_) return auto_choice;
        if (!src_) return pins;
        if (!en_) return nr;
        if (z == 2'h3) return pv;
        return z;
    endfunction

    task automatic final_report();
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 16'h0000; reg_wdata = 8'h00; reset_pulse = 1'b0;
        auto_choice = 2'h0; sel_want = 2'h0; dis = 12'h000;
        prev = 2'h0;
        a_o = 1'b0;
        en_o = 1'b0;
        zd_o = 2'h0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        // Reset values, and an unmapped place that reads zero.
        rd(zero_delay_pkg::ZD_CTRL_ADDR, 8'h00);
        rd(zero_delay_pkg::SOURCE_ADDR, 8'h00);
        rd(zero_delay_pkg::FORCED_LO_ADDR, 8'h00);
        rd(zero_delay_pkg::FORCED_HI_ADDR, 8'h00);
        rd(16'h0600, 8'h00);
        chk_val({10'h0, hitless, use_fb}, 12'h002, "idle loop");
        // New delay only takes effect at a soft reset.
        wr(zero_delay_pkg::DELAY_ADDR, 8'h5a);
        repeat (2) @(posedge core_clk);
        #1 chk_val({4'h0, act_delay}, 12'h000, "staged delay");
        wr(zero_delay_pkg::SOFT_RESET_ADDR, 8'h01);
        @(posedge core_clk);
        #1 chk_val({4'h0, act_delay}, 12'h05a, "latched delay");
        // A write while the clock enable is low must not land.
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(zero_delay_pkg::DELAY_ADDR, 8'h77);
        clk_en <= 1'b1;
        rd(zero_delay_pkg::DELAY_ADDR, 8'h5a);
        // Forced feedback output overrides every disable source.
        wr(zero_delay_pkg::FORCED_HI_ADDR, 8'h08);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            dis <= (i == 0) ? 12'hfff : 12'($random(seed));
            if (i == 6) wr(zero_delay_pkg::FORCED_HI_ADDR, 8'h00);
            repeat (3) @(posedge core_clk);
            #1 chk_val(oen, (i > 5 ? 12'h000 : 12'h800) | ~dis,
                "enables");
        end
        // Random walk over the whole selection table.
        for (int i = 0; i < 40; i++) begin
            {a, en, src, nrm, zd} = 7'($random(seed));
            if (i % 3 == 0) a = 1'b0;
            @(posedge core_clk);
            sel_want <= 2'($random(seed));
            auto_choice <= 2'($random(seed));
            wr(zero_delay_pkg::SOURCE_ADDR, {7'h0, src});
            wr(zero_delay_pkg::NORMAL_SEL_ADDR, {6'h0, nrm});
            wr(zero_delay_pkg::ZD_CTRL_ADDR, {4'h0, a, zd, en});
            repeat (6) @(posedge core_clk);
            // A reserved field keeps what the old control setting chose
            // once source, normal select and pins had already moved.
            #1 hold = exp_sel(a_o, en_o, src, sel_want, nrm, zd_o, prev);
            prev = exp_sel(a, en, src, sel_want, nrm, zd, hold);
            a_o = a;
            en_o = en;
            zd_o = zd;
            chk_val({10'h0, sel}, {10'h0, prev}, "choice");
            chk_val({9'h0, hitless, use_fb, loop_closed},
                {9'h0, !en, en, !en}, "loop path");
        end
        // Outside zero-delay mode the hard reset runs at once.
        wr(zero_delay_pkg::ZD_CTRL_ADDR, 8'h00);
        wr(zero_delay_pkg::HARD_RESET_ADDR, 8'h02);
        count_exec(1'b0);
        chk_cnt(n, 1);
        // In zero-delay mode it is postponed; a repeat is ignored.
        wr(zero_delay_pkg::ZD_CTRL_ADDR, 8'h01);
        wr(zero_delay_pkg::DELAY_ADDR, 8'h33);
        wr(zero_delay_pkg::SOFT_RESET_ADDR, 8'h01);
        wr(zero_delay_pkg::HARD_RESET_ADDR, 8'h02);
        #1 chk_val({11'h0, pend}, 12'h001, "pending");
        count_exec(1'b1);
        chk_cnt(n, HD + 1);
        @(posedge core_clk);
        #1 chk_val({4'h0, act_delay}, 12'h000, "restored delay");
        chk_val({11'h0, pend}, 12'h000, "pending cleared");
        rd(zero_delay_pkg::ZD_CTRL_ADDR, 8'h00);
        rd(zero_delay_pkg::STATUS_ADDR, {6'h00, sel_want});
        final_report();
    end
endmodule // test_zero_delay_input_select

// *** verilog/reset_postpone.sv ***
// Postpones a hard-reset request by a programmable count of cycles.
// Assumes requests are single-cycle pulses on core_clk.
`timescale 1ns/1ns
module reset_postpone #(
    parameter int DELAY_CYCLES = zero_delay_pkg::HARD_DELAY_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic request,
    input wire logic postpone,
    output logic pending,
    output logic execute
);
    initial begin
        if (DELAY_CYCLES < 1) $error("DELAY_CYCLES must be at least one");
    end

    // The counter holds the cycles left; zero means idle.
    logic [31:0] count_r;

    // A request while pending is dropped, so a user cannot extend the wait.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= 32'h0;
            execute <= 1'b0;
        end else if (clk_en) begin
            execute <= 1'b0;
            if (count_r != 32'h0) begin
                count_r <= count_r - 32'h1;
                execute <= (count_r == 32'h1);
            end else if (request && postpone) begin
                count_r <= 32'(DELAY_CYCLES);
            end else if (request) begin
                execute <= 1'b1;
            end
        end
    end
    assign pending = (count_r != 32'h0);

    hold_ignore_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && pending && count_r != 32'h1 |=> pending)
        else $error("pending reset dropped early");
    no_early_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        execute && $past(clk_en) |-> !$past(request) || !$past(postpone)
            || $past(pending))
        else $error("postponed reset ran at once");
endmodule // reset_postpone

// *** verilog/zero_delay_input_select.sv ***
// Zero-delay mode control: input choice, feedback routing, forced
// feedback output, delay latching and postponed hard reset.
// Assumes an 8-bit register port on core_clk; pins are asynchronous.
`timescale 1ns/1ns
module zero_delay_input_select #(
    parameter int HARD_DELAY_CYCLES = zero_delay_pkg::HARD_DELAY_CYCLES,
    parameter int NUM_OUTPUTS = 12
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Register port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Select and reset pins.
    input wire logic input_choice_pin_high,
    input wire logic input_choice_pin_low,
    input wire logic hard_reset_pin_b,
    // Automatic switching engine choice.
    input wire logic [1:0] auto_choice,
    // Output disable sources, one bit per output, high to disable.
    input wire logic [NUM_OUTPUTS-1:0] output_disable,
    output logic [NUM_OUTPUTS-1:0] output_enable,
    output logic [1:0] selected_input,
    output logic hitless_enable,
    output logic use_feedback_input,
    output logic internal_loop_closed,
    output logic [7:0] active_delay,
    output logic hard_reset_pending,
    output logic hard_reset_exec
);
    initial begin
        if (NUM_OUTPUTS != 12) $error("NUM_OUTPUTS must be 12");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    // Two flops per pin; only the second stage is read.
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;

    // Pins settle through two stages; reset pin idles high.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_r <= 3'h4;
            pin_s2_r <= 3'h4;
        end else if (clk_en) begin
            pin_s1_r <= {hard_reset_pin_b, input_choice_pin_high,
                         input_choice_pin_low};
            pin_s2_r <= pin_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    logic zd_en_r; // Zero-delay enable.
    logic [1:0] zd_sel_r; // Zero-delay input field.
    logic auto_sw_r; // Automatic switch enable.
    logic source_r; // Register versus pin source.
    logic [1:0] normal_sel_r; // Normal-mode input select.
    logic [11:0] forced_r; // Forced-output field.
    logic [7:0] delay_staged_r; // Written delay, not yet in use.
    logic [7:0] delay_active_r; // Delay in use.
    logic hard_req; // Hard reset from register or pin.
    logic soft_req; // Soft reset pulse.
    logic pin_prev_r; // Previous synchronised reset pin.
    logic reset_now;

    // Matches the port address against one register address; the strobe is checked by the caller.
    function automatic logic wr_hit(input logic [15:0] a,
                                    input logic [15:0] target);
        return a == target;
    endfunction

    // Configuration writes; a hard reset restores every default.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            zd_en_r <= 1'b0;
            zd_sel_r <= 2'h0;
            auto_sw_r <= 1'b0;
            source_r <= 1'b0;
            normal_sel_r <= 2'h0;
            forced_r <= zero_delay_pkg::FORCED_RESET;
            delay_staged_r <= zero_delay_pkg::DELAY_NVM;
        end else if (clk_en) begin
            if (reset_now) begin
                zd_en_r <= 1'b0;
                zd_sel_r <= 2'h0;
                auto_sw_r <= 1'b0;
                source_r <= 1'b0;
                normal_sel_r <= 2'h0;
                forced_r <= zero_delay_pkg::FORCED_RESET;
                delay_staged_r <= zero_delay_pkg::DELAY_NVM;
            end else if (reg_wr) begin
                if (wr_hit(reg_addr, zero_delay_pkg::ZD_CTRL_ADDR)) begin
                    zd_en_r <= reg_wdata[zero_delay_pkg::ZD_EN_BIT];
                    zd_sel_r <= reg_wdata[zero_delay_pkg::ZD_SEL_LSB +: 2];
                    auto_sw_r <= reg_wdata[zero_delay_pkg::AUTO_SW_BIT];
                end
                if (wr_hit(reg_addr, zero_delay_pkg::SOURCE_ADDR)) begin
                    source_r <= reg_wdata[0];
                end
                if (wr_hit(reg_addr, zero_delay_pkg::NORMAL_SEL_ADDR)) begin
                    normal_sel_r <= reg_wdata[1:0];
                end
                if (wr_hit(reg_addr, zero_delay_pkg::FORCED_LO_ADDR)) begin
                    forced_r[7:0] <= reg_wdata;
                end
                if (wr_hit(reg_addr, zero_delay_pkg::FORCED_HI_ADDR)) begin
                    forced_r[11:8] <= reg_wdata[3:0];
                end
                if (wr_hit(reg_addr, zero_delay_pkg::DELAY_ADDR)) begin
                    delay_staged_r <= reg_wdata;
                end
            end
        end
    end

    // Soft reset latches the staged delay; hard reset restores default.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            delay_active_r <= zero_delay_pkg::DELAY_NVM;
        end else if (clk_en) begin
            if (reset_now) begin
                delay_active_r <= zero_delay_pkg::DELAY_NVM;
            end else if (soft_req) begin
                delay_active_r <= delay_staged_r;
            end
        end
    end
    assign active_delay = delay_active_r;

    ////////////////////////////////////////////////////////////////////////
    // Hard and soft reset requests.

    // Falling edge of the reset pin, seen after synchronisation.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_prev_r <= 1'b1;
        end else if (clk_en) begin
            pin_prev_r <= pin_s2_r[2];
        end
    end

    assign soft_req = reg_wr && reg_wdata[zero_delay_pkg::SOFT_BIT]
        && wr_hit(reg_addr, zero_delay_pkg::SOFT_RESET_ADDR);
    assign hard_req = (pin_prev_r && !pin_s2_r[2])
        || (reg_wr && reg_wdata[zero_delay_pkg::HARD_BIT]
            && wr_hit(reg_addr, zero_delay_pkg::HARD_RESET_ADDR));

    // Only zero-delay mode postpones; the host waits it out.
    reset_postpone #(
        .DELAY_CYCLES(HARD_DELAY_CYCLES)
    ) postpone_u (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .request(hard_req),
        .postpone(zd_en_r),
        .pending(hard_reset_pending),
        .execute(reset_now)
    );
    assign hard_reset_exec = reset_now;

    ////////////////////////////////////////////////////////////////////////
    // Input choice.

    zero_delay_pkg::governor_t gov;
    logic [1:0] choice_nxt;
    logic [1:0] choice_r;

    // Governor per the selection table; auto switching wins outright.
    always_comb begin
        if (auto_sw_r) begin
            gov = zero_delay_pkg::GOV_AUTO;
        end else if (!source_r) begin
            gov = zero_delay_pkg::GOV_PINS;
        end else if (zd_en_r) begin
            gov = zero_delay_pkg::GOV_ZD_REG;
        end else begin
            gov = zero_delay_pkg::GOV_NORMAL_REG;
        end
    end

    // Reserved field value 3 keeps the current input, since input 3
    // is taken by the feedback path.
    always_comb begin
        case (gov)
            zero_delay_pkg::GOV_AUTO: choice_nxt = auto_choice;
            zero_delay_pkg::GOV_PINS: choice_nxt = pin_s2_r[1:0];
            zero_delay_pkg::GOV_ZD_REG: begin
                choice_nxt = (zd_sel_r == 2'h3) ? choice_r : zd_sel_r;
            end
            zero_delay_pkg::GOV_NORMAL_REG: choice_nxt = normal_sel_r;
            default: choice_nxt = choice_r;
        endcase
    end

    // The chosen input is registered so the clock mux sees clean steps.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            choice_r <= 2'h0;
        end else if (clk_en) begin
            choice_r <= choice_nxt;
        end
    end
    assign selected_input = choice_r;

    ////////////////////////////////////////////////////////////////////////
    // Feedback path and outputs.

    assign hitless_enable = !zd_en_r;
    assign use_feedback_input = zd_en_r;
    assign internal_loop_closed = !zd_en_r;

    // Forced field bit 11 pins the feedback output on past any disable.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_out
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    output_enable[gi] <= 1'b0;
                end else if (clk_en) begin
                    output_enable[gi] <= forced_r[gi]
                        || !output_disable[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read-back, registered.

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (clk_en && reg_rd) begin
            case (reg_addr)
                zero_delay_pkg::ZD_CTRL_ADDR:
                    reg_rdata <= {4'h0, auto_sw_r, zd_sel_r, zd_en_r};
                zero_delay_pkg::SOURCE_ADDR: reg_rdata <= {7'h00, source_r};
                zero_delay_pkg::NORMAL_SEL_ADDR:
                    reg_rdata <= {6'h00, normal_sel_r};
                zero_delay_pkg::FORCED_LO_ADDR: reg_rdata <= forced_r[7:0];
                zero_delay_pkg::FORCED_HI_ADDR:
                    reg_rdata <= {4'h0, forced_r[11:8]};
                zero_delay_pkg::DELAY_ADDR: reg_rdata <= delay_staged_r;
                zero_delay_pkg::STATUS_ADDR:
                    reg_rdata <= {5'h00, hard_reset_pending, choice_r};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    auto_wins_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && auto_sw_r |=> selected_input == $past(auto_choice))
        else $error("auto switch did not govern");
    zd_field_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && !auto_sw_r && zd_en_r && source_r && zd_sel_r != 2'h3
        |=> selected_input == $past(zd_sel_r))
        else $error("zero-delay field not used");
    pins_used_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && !auto_sw_r && !source_r
        |=> selected_input == $past(pin_s2_r[1:0]))
        else $error("pins not used");
    reserved_sel_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && !auto_sw_r && zd_en_r && source_r && zd_sel_r == 2'h3
        |=> selected_input == $past(selected_input))
        else $error("reserved input not held");
    feedback_on_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && forced_r[11] |=> output_enable[11])
        else $error("feedback output not forced");
    zd_mode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        zd_en_r |-> use_feedback_input && !hitless_enable
        && !internal_loop_closed)
        else $error("zero-delay routing wrong");
    soft_latch_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && soft_req && !reset_now
        |=> active_delay == $past(delay_staged_r))
        else $error("delay not latched");
    postpone_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && hard_req && zd_en_r && !hard_reset_pending
        |=> hard_reset_pending && !reset_now)
        else $error("hard reset not postponed");
    src_reg_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && reg_wr && reg_addr == zero_delay_pkg::SOURCE_ADDR
        && !reset_now |=> source_r == $past(reg_wdata[0]))
        else $error("source bit not written");
    zd_cov_c: cover property (@(posedge core_clk) gov ==
        zero_delay_pkg::GOV_ZD_REG);
    auto_cov_c: cover property (@(posedge core_clk) auto_sw_r);
    wait_cov_c: cover property (@(posedge core_clk) hard_reset_pending);
endmodule // zero_delay_input_select

// *** verilog/zero_delay_pkg.sv ***
// Constants shared by the zero-delay input selection block.
// Assumes an 8-bit register port with 16-bit addresses, one device clock.
// Operation
// - Zero-delay off while enable is 0.
// - Source bit picks pins or zero-delay field.
// - Field values 0..2 pick inputs; 3 reserved.
// - Register source ignores normal select register.
// - Manual choice table without automatic switching.
// - Automatic switch enable overrides all manual selection.
// - No hitless switching in zero-delay mode.
// - Hard reset postponed about 750 ms.
// - Forced-output value 0x800 keeps feedback output on.
// - Zero-delay mode uses external feedback input.
// - Soft reset latches delays; hard reset restores.
package zero_delay_pkg;
    // Register addresses and field positions.
    localparam logic [15:0] SOFT_RESET_ADDR = 16'h001c;
    localparam logic [15:0] HARD_RESET_ADDR = 16'h001e;
    localparam logic [15:0] FORCED_LO_ADDR = 16'h013f;
    localparam logic [15:0] FORCED_HI_ADDR = 16'h0140;
    localparam logic [15:0] ZD_CTRL_ADDR = 16'h0487;
    localparam logic [15:0] SOURCE_ADDR = 16'h052a;
    localparam logic [15:0] NORMAL_SEL_ADDR = 16'h052b;
    localparam logic [15:0] DELAY_ADDR = 16'h0359;
    localparam logic [15:0] STATUS_ADDR = 16'h0490;
    localparam int ZD_EN_BIT = 0;
    localparam int ZD_SEL_LSB = 1;
    localparam int AUTO_SW_BIT = 3;
    localparam int SOFT_BIT = 0;
    localparam int HARD_BIT = 1;
    // Reset values and the forced-feedback value.
    localparam logic [11:0] FORCED_RESET = 12'h000;
    localparam logic [11:0] FORCED_FEEDBACK = 12'h800;
    localparam logic [7:0] DELAY_NVM = 8'h00;
    // Postponed hard reset timing at 25 MHz.
    localparam int CLK_PERIOD_NS = 40;
    localparam int HARD_DELAY_MS = 750;
    localparam int HARD_DELAY_CYCLES = HARD_DELAY_MS * 1000000 / CLK_PERIOD_NS;
    // Who governs the input choice.
    typedef enum logic [1:0] {
        GOV_PINS, GOV_NORMAL_REG, GOV_ZD_REG, GOV_AUTO
    } governor_t;
endpackage
